// ### core/dsmod_pkg.sv
// package: register map, field positions, reset values and source codes of the data signal modulator
package dsmod_pkg;

   // =====================================================================
   // register indices; the byte address is four times the index
   localparam logic [11:0] IDX_CTRL_MAIN = 12'hf4c;
   localparam logic [11:0] IDX_SYNC_POL = 12'hf4d;
   localparam logic [11:0] IDX_SRC_SEL = 12'hf4e;
   localparam logic [11:0] IDX_LOW_SEL = 12'hf4f;
   localparam logic [11:0] IDX_HIGH_SEL = 12'hf50;
   localparam int ADDR_W = 14;

   // =====================================================================
   // field positions
   localparam int MAIN_EN_BIT = 7;
   localparam int MAIN_OUT_BIT = 5;
   localparam int MAIN_OINV_BIT = 4;
   localparam int MAIN_SWBIT_BIT = 0;
   localparam int SP_HINV_BIT = 5;
   localparam int SP_HSYNC_BIT = 4;
   localparam int SP_LINV_BIT = 1;
   localparam int SP_LSYNC_BIT = 0;
   localparam int SRC_W = 5;
   localparam int CAR_W = 4;

   // =====================================================================
   // values after reset
   localparam logic RST_BIT = 1'b0;
   localparam logic [4:0] RST_SRC = 5'h00;
   localparam logic [3:0] RST_CAR = 4'h0;

   // =====================================================================
   // modulator source codes
   localparam logic [4:0] SRC_PIN = 5'h00;
   localparam logic [4:0] SRC_SW_BIT = 5'h01;
   localparam logic [4:0] SRC_CCP0 = 5'h02;
   localparam logic [4:0] SRC_PWM0 = 5'h04;
   localparam logic [4:0] SRC_CMP0 = 5'h06;
   localparam logic [4:0] SRC_SER0_DT = 5'h08;
   localparam logic [4:0] SRC_SER0_TX = 5'h09;
   localparam logic [4:0] SRC_SPI0 = 5'h0a;
   localparam logic [4:0] SRC_SPI1 = 5'h0b;
   localparam logic [4:0] SRC_SER1_DT = 5'h0c;
   localparam logic [4:0] SRC_SER1_TX = 5'h0d;
   localparam logic [4:0] SRC_RSV0 = 5'h0e;
   localparam logic [4:0] SRC_RSV1 = 5'h0f;
   localparam logic [4:0] SRC_CLC0 = 5'h10;
   localparam logic [4:0] SRC_RSV_HI = 5'h18;

   // =====================================================================
   // carrier codes, shared by both carrier selects
   localparam logic [3:0] CAR_PIN = 4'h0;
   localparam logic [3:0] CAR_SYSCLK = 4'h1;
   localparam logic [3:0] CAR_FASTOSC = 4'h2;
   localparam logic [3:0] CAR_REFCLK = 4'h3;
   localparam logic [3:0] CAR_CCP0 = 4'h4;
   localparam logic [3:0] CAR_PWM0 = 4'h6;
   localparam logic [3:0] CAR_CLC0 = 4'h8;

   // =====================================================================
   // input synchroniser slots for off-domain inputs
   localparam int NSYNC = 6;
   localparam int SY_MODPIN = 0;
   localparam int SY_HPIN = 1;
   localparam int SY_LPIN = 2;
   localparam int SY_SYSCLK = 3;
   localparam int SY_FASTOSC = 4;
   localparam int SY_REFCLK = 5;

endpackage

// ### core/dsmod_sync3.sv
// module: three-stage input synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ns
module dsmod_sync3 (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // raw asynchronous level and its clean version
   input wire logic async_in,
   output logic sync_out
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // only stages two and three are compared; stage one may be metastable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_out <= 1'b0;
      end else if (s2_q == s3_q) begin
         sync_out <= s3_q;
      end
   end

endmodule

// ### core/dsmod_top.sv
// module: data signal modulator core with its avalon register slave
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module dsmod_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // avalon-mm register slave
   input wire logic [dsmod_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // power gate from the peripheral power controller
   input wire logic modulator_module_disable,
   // pins and free-running clocks, outside this domain
   input wire logic mod_source_pin_route,
   input wire logic high_carrier_pin_route,
   input wire logic low_carrier_pin_route,
   input wire logic system_clock_source,
   input wire logic fast_internal_oscillator,
   input wire logic reference_clock_out,
   // on-chip peripheral outputs, same clock
   input wire logic [1:0] capture_compare_output,
   input wire logic [1:0] pulse_width_output,
   input wire logic [1:0] comparator_output,
   input wire logic [1:0] serial_port_data_output,
   input wire logic [1:0] serial_port_tx_output,
   input wire logic [1:0] sync_serial_data_out,
   input wire logic [7:0] logic_cell_output,
   // modulated output
   output logic modulated_output_pin
);

   // =====================================================================
   // decoding helpers
   function automatic logic reg_hit(input logic [dsmod_pkg::ADDR_W-1:0] a, input logic [11:0] idx);
      logic [dsmod_pkg::ADDR_W-1:0] byte_addr;
      byte_addr = {idx, 2'b00};
      reg_hit = (a == byte_addr);
   endfunction

   function automatic logic pick16(input logic [15:0] vec, input logic [3:0] sel);
      pick16 = vec[sel];
   endfunction

   // =====================================================================
   // input synchronisers for pins and foreign clocks
   logic [dsmod_pkg::NSYNC-1:0] raw_async;
   logic [dsmod_pkg::NSYNC-1:0] clean_async;

   assign raw_async[dsmod_pkg::SY_MODPIN] = mod_source_pin_route;
   assign raw_async[dsmod_pkg::SY_HPIN] = high_carrier_pin_route;
   assign raw_async[dsmod_pkg::SY_LPIN] = low_carrier_pin_route;
   assign raw_async[dsmod_pkg::SY_SYSCLK] = system_clock_source;
   assign raw_async[dsmod_pkg::SY_FASTOSC] = fast_internal_oscillator;
   assign raw_async[dsmod_pkg::SY_REFCLK] = reference_clock_out;

   // clocks faster than a quarter of clk alias after sampling; a known limitation
   generate
      for (genvar gi = 0; gi < dsmod_pkg::NSYNC; gi++) begin : g_sync
         dsmod_sync3 u_sync (
            .clk(clk),
            .rst_n(rst_n),
            .async_in(raw_async[gi]),
            .sync_out(clean_async[gi])
         );
      end
   endgenerate

   // =====================================================================
   // configuration registers
   logic en_q;
   logic output_invert_q;
   logic software_mod_bit_q;
   logic high_carrier_invert_q;
   logic high_carrier_sync_en_q;
   logic low_carrier_invert_q;
   logic low_carrier_sync_en_q;
   logic [dsmod_pkg::SRC_W-1:0] mod_source_sel_q;
   logic [dsmod_pkg::CAR_W-1:0] low_carrier_sel_q;
   logic [dsmod_pkg::CAR_W-1:0] high_carrier_sel_q;
   logic out_q;

   // =====================================================================
   // bus handshake: one wait state per access
   logic ack_q;
   logic req;
   logic accept;
   logic wr_ok;
   logic hit_main;
   logic hit_sp;
   logic hit_src;
   logic hit_low;
   logic hit_high;

   assign req = read | write;
   assign waitrequest = req & ~ack_q;
   assign accept = req & ack_q;
   assign wr_ok = accept & write & byteenable[0] & ~modulator_module_disable;
   assign hit_main = reg_hit(address, dsmod_pkg::IDX_CTRL_MAIN);
   assign hit_sp = reg_hit(address, dsmod_pkg::IDX_SYNC_POL);
   assign hit_src = reg_hit(address, dsmod_pkg::IDX_SRC_SEL);
   assign hit_low = reg_hit(address, dsmod_pkg::IDX_LOW_SEL);
   assign hit_high = reg_hit(address, dsmod_pkg::IDX_HIGH_SEL);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // power gate holds every register at its default, so release finds defaults
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= dsmod_pkg::RST_BIT;
         output_invert_q <= dsmod_pkg::RST_BIT;
         software_mod_bit_q <= dsmod_pkg::RST_BIT;
      end else if (modulator_module_disable) begin
         en_q <= dsmod_pkg::RST_BIT;
         output_invert_q <= dsmod_pkg::RST_BIT;
         software_mod_bit_q <= dsmod_pkg::RST_BIT;
      end else if (wr_ok && hit_main) begin
         en_q <= writedata[dsmod_pkg::MAIN_EN_BIT];
         output_invert_q <= writedata[dsmod_pkg::MAIN_OINV_BIT];
         software_mod_bit_q <= writedata[dsmod_pkg::MAIN_SWBIT_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_carrier_invert_q <= dsmod_pkg::RST_BIT;
         high_carrier_sync_en_q <= dsmod_pkg::RST_BIT;
         low_carrier_invert_q <= dsmod_pkg::RST_BIT;
         low_carrier_sync_en_q <= dsmod_pkg::RST_BIT;
      end else if (modulator_module_disable) begin
         high_carrier_invert_q <= dsmod_pkg::RST_BIT;
         high_carrier_sync_en_q <= dsmod_pkg::RST_BIT;
         low_carrier_invert_q <= dsmod_pkg::RST_BIT;
         low_carrier_sync_en_q <= dsmod_pkg::RST_BIT;
      end else if (wr_ok && hit_sp) begin
         high_carrier_invert_q <= writedata[dsmod_pkg::SP_HINV_BIT];
         high_carrier_sync_en_q <= writedata[dsmod_pkg::SP_HSYNC_BIT];
         low_carrier_invert_q <= writedata[dsmod_pkg::SP_LINV_BIT];
         low_carrier_sync_en_q <= writedata[dsmod_pkg::SP_LSYNC_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_source_sel_q <= dsmod_pkg::RST_SRC;
         low_carrier_sel_q <= dsmod_pkg::RST_CAR;
         high_carrier_sel_q <= dsmod_pkg::RST_CAR;
      end else if (modulator_module_disable) begin
         mod_source_sel_q <= dsmod_pkg::RST_SRC;
         low_carrier_sel_q <= dsmod_pkg::RST_CAR;
         high_carrier_sel_q <= dsmod_pkg::RST_CAR;
      end else if (wr_ok) begin
         if (hit_src) begin
            mod_source_sel_q <= writedata[dsmod_pkg::SRC_W-1:0];
         end else if (hit_low) begin
            low_carrier_sel_q <= writedata[dsmod_pkg::CAR_W-1:0];
         end else if (hit_high) begin
            high_carrier_sel_q <= writedata[dsmod_pkg::CAR_W-1:0];
         end
      end
   end

   // read data captured in the wait cycle, so it stands when waitrequest drops
   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      if (modulator_module_disable) begin
         rd_byte = 8'h00;
      end else if (hit_main) begin
         rd_byte[dsmod_pkg::MAIN_EN_BIT] = en_q;
         rd_byte[dsmod_pkg::MAIN_OUT_BIT] = out_q;
         rd_byte[dsmod_pkg::MAIN_OINV_BIT] = output_invert_q;
         rd_byte[dsmod_pkg::MAIN_SWBIT_BIT] = software_mod_bit_q;
      end else if (hit_sp) begin
         rd_byte[dsmod_pkg::SP_HINV_BIT] = high_carrier_invert_q;
         rd_byte[dsmod_pkg::SP_HSYNC_BIT] = high_carrier_sync_en_q;
         rd_byte[dsmod_pkg::SP_LINV_BIT] = low_carrier_invert_q;
         rd_byte[dsmod_pkg::SP_LSYNC_BIT] = low_carrier_sync_en_q;
      end else if (hit_src) begin
         rd_byte[dsmod_pkg::SRC_W-1:0] = mod_source_sel_q;
      end else if (hit_low) begin
         rd_byte[dsmod_pkg::CAR_W-1:0] = low_carrier_sel_q;
      end else if (hit_high) begin
         rd_byte[dsmod_pkg::CAR_W-1:0] = high_carrier_sel_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= 32'h0000_0000;
      end else if (read && !ack_q) begin
         readdata <= {24'h00_0000, rd_byte};
      end
   end

   // =====================================================================
   // source multiplexers
   logic [31:0] src_vec;
   logic [15:0] high_vec;
   logic [15:0] low_vec;
   logic mod_sig;
   logic high_raw;
   logic low_raw;
   logic high_pol;
   logic low_pol;

   always_comb begin
      src_vec = 32'h0000_0000;
      src_vec[dsmod_pkg::SRC_PIN] = clean_async[dsmod_pkg::SY_MODPIN];
      src_vec[dsmod_pkg::SRC_SW_BIT] = software_mod_bit_q;
      src_vec[dsmod_pkg::SRC_CCP0 +: 2] = capture_compare_output;
      src_vec[dsmod_pkg::SRC_PWM0 +: 2] = pulse_width_output;
      src_vec[dsmod_pkg::SRC_CMP0 +: 2] = comparator_output;
      src_vec[dsmod_pkg::SRC_SER0_DT] = serial_port_data_output[0];
      src_vec[dsmod_pkg::SRC_SER0_TX] = serial_port_tx_output[0];
      src_vec[dsmod_pkg::SRC_SPI0] = sync_serial_data_out[0];
      src_vec[dsmod_pkg::SRC_SPI1] = sync_serial_data_out[1];
      src_vec[dsmod_pkg::SRC_SER1_DT] = serial_port_data_output[1];
      src_vec[dsmod_pkg::SRC_SER1_TX] = serial_port_tx_output[1];
      src_vec[dsmod_pkg::SRC_CLC0 +: 8] = logic_cell_output;
   end

   assign mod_sig = src_vec[mod_source_sel_q];

   always_comb begin
      high_vec = 16'h0000;
      high_vec[dsmod_pkg::CAR_PIN] = clean_async[dsmod_pkg::SY_HPIN];
      high_vec[dsmod_pkg::CAR_SYSCLK] = clean_async[dsmod_pkg::SY_SYSCLK];
      high_vec[dsmod_pkg::CAR_FASTOSC] = clean_async[dsmod_pkg::SY_FASTOSC];
      high_vec[dsmod_pkg::CAR_REFCLK] = clean_async[dsmod_pkg::SY_REFCLK];
      high_vec[dsmod_pkg::CAR_CCP0 +: 2] = capture_compare_output;
      high_vec[dsmod_pkg::CAR_PWM0 +: 2] = pulse_width_output;
      high_vec[dsmod_pkg::CAR_CLC0 +: 8] = logic_cell_output;
      low_vec = high_vec;
      low_vec[dsmod_pkg::CAR_PIN] = clean_async[dsmod_pkg::SY_LPIN];
   end

   assign high_raw = pick16(high_vec, high_carrier_sel_q);
   assign low_raw = pick16(low_vec, low_carrier_sel_q);
   assign high_pol = high_raw ^ high_carrier_invert_q;
   assign low_pol = low_raw ^ low_carrier_invert_q;

   // =====================================================================
   // carrier selection with optional synchronisation
   logic sel_high_q;
   logic sel_high_d;

   always_comb begin
      sel_high_d = sel_high_q;
      if (sel_high_q && !mod_sig) begin
         // a synced high carrier must finish its pulse first
         sel_high_d = high_carrier_sync_en_q && high_pol;
      end else if (!sel_high_q && mod_sig) begin
         sel_high_d = !low_carrier_sync_en_q || !low_pol;
      end
   end

   // runs only from clk and the selected sources, so it follows them into sleep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_high_q <= 1'b0;
      end else if (modulator_module_disable) begin
         sel_high_q <= 1'b0;
      end else begin
         sel_high_q <= sel_high_d;
      end
   end

   // =====================================================================
   // mixing and output stage
   logic mixed;

   assign mixed = sel_high_q ? high_pol : low_pol;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= 1'b0;
      end else if (modulator_module_disable || !en_q) begin
         out_q <= 1'b0;
      end else begin
         out_q <= mixed ^ output_invert_q;
      end
   end

   assign modulated_output_pin = out_q;

   // =====================================================================
   // checks
   sequence seq_high_pulse_pending;
      sel_high_q && high_carrier_sync_en_q && high_pol && !mod_sig;
   endsequence

   sequence seq_low_free;
      !sel_high_q && !low_carrier_sync_en_q && mod_sig;
   endsequence

   chk_disable_low: assert property (@(posedge clk) disable iff (!rst_n)
      !en_q |=> !modulated_output_pin)
      else $error("output not low while disabled");

   chk_invert_idle: assert property (@(posedge clk) disable iff (!rst_n)
      en_q && output_invert_q && !mixed && !modulator_module_disable |=> modulated_output_pin)
      else $error("inverted output not high for low mix");

   chk_noinv_follow: assert property (@(posedge clk) disable iff (!rst_n)
      en_q && !output_invert_q && !modulator_module_disable |=> modulated_output_pin == $past(mixed))
      else $error("output does not follow mix");

   chk_sw_source: assert property (@(posedge clk) disable iff (!rst_n)
      mod_source_sel_q == dsmod_pkg::SRC_SW_BIT |-> mod_sig == software_mod_bit_q)
      else $error("software bit not used as modulator");

   chk_reserved_low: assert property (@(posedge clk) disable iff (!rst_n)
      (mod_source_sel_q >= dsmod_pkg::SRC_RSV_HI || mod_source_sel_q == dsmod_pkg::SRC_RSV0
       || mod_source_sel_q == dsmod_pkg::SRC_RSV1) |-> !mod_sig)
      else $error("reserved source not low");

   chk_sync_hold: assert property (@(posedge clk) disable iff (!rst_n)
      seq_high_pulse_pending and !modulator_module_disable |=> sel_high_q)
      else $error("switched away during high pulse");

   chk_nosync_switch: assert property (@(posedge clk) disable iff (!rst_n)
      seq_low_free and !modulator_module_disable |=> sel_high_q)
      else $error("unsynced low carrier did not switch");

   chk_high_mix: assert property (@(posedge clk) disable iff (!rst_n)
      sel_high_q |-> mixed == (high_raw ^ high_carrier_invert_q))
      else $error("high carrier not mixed");

   chk_gate_clears: assert property (@(posedge clk) disable iff (!rst_n)
      modulator_module_disable |=> !en_q && mod_source_sel_q == dsmod_pkg::RST_SRC
      && high_carrier_sel_q == dsmod_pkg::RST_CAR && !high_carrier_sync_en_q)
      else $error("registers not defaulted by power gate");

   chk_status_read: assert property (@(posedge clk) disable iff (!rst_n)
      accept && read && hit_main && !modulator_module_disable && !$past(modulator_module_disable)
      |-> readdata[dsmod_pkg::MAIN_OUT_BIT] == $past(out_q))
      else $error("status bit differs from output");

   chk_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
      req && !ack_q |-> waitrequest ##1 (!req || !waitrequest))
      else $error("bus answer not after one wait");

endmodule

// ### dv/dsmod_periph_model.sv
// partner: peripheral outputs and pins that feed the modulator
`timescale 1ns/1ns
module dsmod_periph_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // run selects free-running cells, level the static value
   input wire logic run,
   input wire logic level,
   // sources
   output logic pin_m,
   output logic pin_h,
   output logic pin_l,
   output logic [2:0] clks,
   output logic [11:0] periph,
   output logic [7:0] cells
);
   logic [8:0] cnt_q;

   // ==========
   // cells keep running on their own, like in sleep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 9'h000;
      end else begin
         cnt_q <= cnt_q + 9'h001;
      end
   end
   assign pin_m = level;
   assign pin_h = level;
   assign pin_l = level;
   assign clks = {3{level}};
   assign periph = {12{level}};
   // cell 0 stays static so it can serve as a quiet low carrier
   assign cells = run ? {cnt_q[8:2], level} : {8{level}};
endmodule

// ### dv/test_dsmod_top.sv
// testbench: registers, source muxes, polarity, sync and power gate of the modulator
`timescale 1ns/1ns
module test_dsmod_top;
   localparam logic [11:0] MN = dsmod_pkg::IDX_CTRL_MAIN;
   localparam logic [11:0] SP = dsmod_pkg::IDX_SYNC_POL;
   localparam logic [11:0] SR = dsmod_pkg::IDX_SRC_SEL;
   localparam logic [11:0] LO = dsmod_pkg::IDX_LOW_SEL;
   localparam logic [11:0] HI = dsmod_pkg::IDX_HIGH_SEL;
   logic clk, rst_n, read, write, waitrequest, pd, run, level, out, pin_m, pin_h, pin_l;
   logic [dsmod_pkg::ADDR_W-1:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata;
   logic [2:0] clks;
   logic [11:0] periph;
   logic [7:0] cells, rd, e;
   int fail_count, num_checks;

   dsmod_top dsmod_top_inst (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .modulator_module_disable(pd), .mod_source_pin_route(pin_m), .high_carrier_pin_route(pin_h),
      .low_carrier_pin_route(pin_l), .system_clock_source(clks[0]), .fast_internal_oscillator(clks[1]),
      .reference_clock_out(clks[2]), .capture_compare_output(periph[1:0]), .pulse_width_output(periph[3:2]),
      .comparator_output(periph[5:4]), .serial_port_data_output(periph[7:6]),
      .serial_port_tx_output(periph[9:8]), .sync_serial_data_out(periph[11:10]),
      .logic_cell_output(cells), .modulated_output_pin(out));
   dsmod_periph_model dsmod_periph_model_inst (.clk(clk), .rst_n(rst_n), .run(run), .level(level),
      .pin_m(pin_m), .pin_h(pin_h), .pin_l(pin_l), .clks(clks), .periph(periph), .cells(cells));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ==========
   // helpers
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   // waitrequest is read at the rising edge, before that edge's updates land
   task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
      int k;
      @(posedge clk);
      address <= {idx, 2'b00};
      writedata <= {24'h000000, d};
      write <= w;
      read <= !w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (waitrequest && k < 20);
      if (k >= 20) begin
         fail_count++;
         results();
      end
      rd = readdata[7:0];
      write <= 1'b0;
      read <= 1'b0;
   endtask

   task automatic wait_pin(input logic v);
      int k;
      k = 0;
      while (out !== v && k < 300) begin
         @(negedge clk);
         k++;
      end
      if (k >= 300) begin
         fail_count++;
         results();
      end
   endtask

   task automatic look(input logic v);
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk({7'h00, v}, {7'h00, out});
   endtask

   // ==========
   // main sequence
   initial begin
      rst_n = 1'b0;
      address = '0;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'h1;
      writedata = '0;
      pd = 1'b0;
      run = 1'b0;
      level = 1'b0;
      fail_count = 0;
      num_checks = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, MN + 12'(i), 8'h00);
         chk(8'h00, rd);
      end
      bus(1'b1, MN, 8'hff);
      bus(1'b0, MN, 8'h00);
      chk(8'hb1, rd);
      bus(1'b1, SP, 8'hff);
      bus(1'b0, SP, 8'h00);
      chk(8'h33, rd);
      bus(1'b1, LO, 8'hff);
      bus(1'b0, LO, 8'h00);
      chk(8'h0f, rd);
      bus(1'b1, HI, 8'hff);
      bus(1'b0, HI, 8'h00);
      chk(8'h0f, rd);
      bus(1'b1, SR, 8'hff);
      byteenable <= 4'h0;
      bus(1'b1, SR, 8'h00);
      byteenable <= 4'h1;
      bus(1'b0, SR, 8'h00);
      chk(8'h1f, rd);
      // every carrier code on both sides, both levels, with polarity mixes
      bus(1'b1, SR, {3'b000, dsmod_pkg::SRC_SW_BIT});
      for (int s = 0; s < 2; s++) begin
         for (int l = 0; l < 2; l++) begin
            for (int c = 0; c < 16; c++) begin
               level <= l[0];
               bus(1'b1, s[0] ? HI : LO, 8'(c));
               bus(1'b1, SP, s[0] ? {2'b00, c[0], 5'h00} : {6'h00, c[0], 1'b0});
               bus(1'b1, MN, {3'b100, c[1], 3'b000, s[0]});
               e = {7'h00, l[0] ^ c[0] ^ c[1]};
               look(e[0]);
               bus(1'b0, MN, 8'h00);
               chk({2'b10, e[0], c[1], 3'b000, s[0]}, rd);
            end
         end
      end
      // every source code: high carrier steady one, low carrier inverted to zero
      level <= 1'b1;
      bus(1'b1, HI, {4'h0, dsmod_pkg::CAR_CLC0});
      bus(1'b1, LO, {4'h0, dsmod_pkg::CAR_CLC0});
      bus(1'b1, SP, 8'h02);
      bus(1'b1, MN, 8'h80);
      for (int c = 0; c < 32; c++) begin
         bus(1'b1, SR, 8'(c));
         look(c != 1 && c != 14 && c != 15 && c < 24);
      end
      bus(1'b1, SR, {3'b000, dsmod_pkg::SRC_SW_BIT});
      bus(1'b1, MN, 8'h90);
      look(1'b1);
      bus(1'b1, MN, 8'h11);
      look(1'b0);
      bus(1'b0, SR, 8'h00);
      chk(8'h01, rd);
      pd <= 1'b1;
      bus(1'b0, SR, 8'h00);
      chk(8'h00, rd);
      bus(1'b1, SR, 8'h05);
      pd <= 1'b0;
      bus(1'b0, SR, 8'h00);
      chk(8'h00, rd);
      look(1'b0);
      // drop the modulator mid-pulse under each sync combination
      @(posedge clk);
      level <= 1'b0;
      run <= 1'b1;
      bus(1'b1, HI, 8'h0c);
      bus(1'b1, LO, 8'h08);
      bus(1'b1, SR, {3'b000, dsmod_pkg::SRC_SW_BIT});
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, SP, {3'b000, m[1], 3'b000, m[0]});
         bus(1'b1, MN, 8'h81);
         wait_pin(1'b0);
         wait_pin(1'b1);
         bus(1'b1, MN, 8'h80);
         repeat (6) @(posedge clk);
         @(negedge clk);
         chk({7'h00, m[1]}, {7'h00, out});
      end
      // reset in mid-run
      bus(1'b1, SR, 8'h1f);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, SR, 8'h00);
      chk(8'h00, rd);
      results();
   end
endmodule
